// ### rtl/adcsq_map.vh
// Register map, field positions and timing counts for the converter sequencer
`ifndef ADCSQ_MAP_VH
`define ADCSQ_MAP_VH
`define ADCSQ_OFS_CTRL       12'h000
`define ADCSQ_OFS_OPTION     12'h004
`define ADCSQ_OFS_RESULT0    12'h010
`define ADCSQ_OFS_STATUS     12'h030
`define ADCSQ_CTRL_DONE      7
`define ADCSQ_CTRL_EIGHT     6
`define ADCSQ_CTRL_SCAN      5
`define ADCSQ_CTRL_MULTI     4
`define ADCSQ_OPT_PWR        0
`define ADCSQ_OPT_CLKSEL     1
`define ADCSQ_CTRL_RESET     8'h00
`define ADCSQ_OPT_RESET      2'h0
`define ADCSQ_GROUP_CYCLES   144
`define ADCSQ_CONV_CYCLES    36
`define ADCSQ_SAMPLE_CYCLES  4
`define ADCSQ_RES_BITS       10
`endif

// ### rtl/adcsq_sar.v
// Successive approximation bit search for one conversion
`timescale 1ns/1ps
module adcsq_sar #(
   parameter WIDTH = 10
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire             abort,
   input  wire             step,
   input  wire             start,
   input  wire             cmp_above,
   output wire [WIDTH-1:0] dac_code,
   output reg              done_ff
);
   reg [WIDTH-1:0] trial_ff;
   reg [WIDTH-1:0] bit_ff;
   reg             busy_ff;
   assign dac_code = trial_ff | bit_ff;
   // Compare DAC output against held sample, one bit per step
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trial_ff <= {WIDTH{1'b0}};
         bit_ff   <= {WIDTH{1'b0}};
         busy_ff  <= 1'b0;
         done_ff  <= 1'b0;
      end else if (abort) begin
         trial_ff <= {WIDTH{1'b0}};
         bit_ff   <= {WIDTH{1'b0}};
         busy_ff  <= 1'b0;
         done_ff  <= 1'b0;
      end else if (start) begin
         trial_ff <= {WIDTH{1'b0}};
         bit_ff   <= {1'b1, {(WIDTH-1){1'b0}}};
         busy_ff  <= 1'b1;
         done_ff  <= 1'b0;
      end else if (busy_ff && step) begin
         if (cmp_above) begin
            trial_ff <= trial_ff | bit_ff;
         end
         bit_ff  <= bit_ff >> 1;
         busy_ff <= ~bit_ff[0];
         done_ff <= bit_ff[0];
      end else begin
         done_ff <= 1'b0;
      end
   end
endmodule // adcsq_sar

// ### rtl/adcsq_top.v
// Converter sequencer control with APB registers
// Summary of operation
// - One 10-bit converter, sixteen-way input mux
// - Eight results; four or eight, stop or loop
// - Bus clock: four conversions in 144 cycles
// - Oscillator converts; results move on bus clock
// - Power-on clear disables and aborts conversion
// - Clock-select bit picks conversion clock source
// - Left-justified 16-bit ratiometric result, saturating
// - Six low result bits read zero
// - Sample input, then successive DAC compares
// - Four-bit code picks pins or internal points
// - Reserved channels tied to low reference
// - Multi-channel register placement by code
// - Single channel converted four or eight times
// - Four-conversion scan fills registers 5 to 8
// - Select clear bus clock, set oscillator
// - Control write clears flag, aborts, restarts
`timescale 1ns/1ps
`include "adcsq_map.vh"
module adcsq_top #(
   parameter RES_BITS = `ADCSQ_RES_BITS
) (
   input  wire                pclk,
   input  wire                presetn,
   input  wire                psel,
   input  wire                penable,
   input  wire                pwrite,
   input  wire [11:0]         paddr,
   input  wire [31:0]         pwdata,
   output wire                pready,
   output reg  [31:0]         prdata,
   output wire                pslverr,
   input  wire                osc_clk,
   input  wire                cmp_above,
   output reg  [3:0]          mux_sel_ff,
   output reg                 sample_hold_ff,
   output wire [RES_BITS-1:0] dac_code,
   output reg                 converter_power_on_ff
);
   localparam ST_IDLE   = 3'b001;
   localparam ST_SAMPLE = 3'b010;
   localparam ST_CONV   = 3'b100;
   reg [7:0]  ctrl_ff;
   reg        clk_sel_ff;
   reg [2:0]  state_ff;
   reg [2:0]  nxt_state;
   reg [2:0]  count_ff;
   reg [2:0]  nxt_count;
   reg [5:0]  tick_ff;
   reg [RES_BITS-1:0] result_ff [0:7];
   reg [7:0]  conv_total_ff;
   reg        osc_s1_ff;
   reg        osc_s2_ff;
   reg        osc_s3_ff;
   reg        cmp_s1_ff;
   reg        cmp_s2_ff;
   wire       wr_en;
   wire       rd_en;
   wire       ctrl_wr;
   wire       osc_rise;
   wire       step;
   wire       sar_done;
   wire       sar_start;
   wire       sar_step;
   wire       abort;
   wire       eight_sel;
   wire       scan;
   wire       multi_sel;
   wire [3:0] chan_code;
   reg  [3:0] cur_chan;
   reg  [2:0] cur_slot;
   reg  [3:0] eff_chan;
   integer    i;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~penable & ~pwrite;
   assign ctrl_wr = wr_en & (paddr == `ADCSQ_OFS_CTRL);
   assign eight_sel = ctrl_ff[`ADCSQ_CTRL_EIGHT];
   assign scan      = ctrl_ff[`ADCSQ_CTRL_SCAN];
   assign multi_sel = ctrl_ff[`ADCSQ_CTRL_MULTI];
   assign chan_code = ctrl_ff[3:0];
   // Oscillator edge taken after two flops; result capture stays on pclk
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_s1_ff <= 1'b0;
         osc_s2_ff <= 1'b0;
         osc_s3_ff <= 1'b0;
         cmp_s1_ff <= 1'b0;
         cmp_s2_ff <= 1'b0;
      end else begin
         osc_s1_ff <= osc_clk;
         osc_s2_ff <= osc_s1_ff;
         osc_s3_ff <= osc_s2_ff;
         cmp_s1_ff <= cmp_above;
         cmp_s2_ff <= cmp_s1_ff;
      end
   end
   assign osc_rise = osc_s2_ff & ~osc_s3_ff;
   // Bus clock path: one sequencer tick per bus cycle, 36 cycles per conversion
   // Oscillator path: one step per synchronised oscillator edge
   assign step  = clk_sel_ff ? osc_rise : 1'b1;
   assign abort = ctrl_wr | ~converter_power_on_ff;
   // Sequence position to channel and result slot
   always @* begin
      cur_chan = chan_code;
      cur_slot = 3'd0;
      if (multi_sel && eight_sel) begin
         cur_chan = {1'b0, count_ff};
         cur_slot = count_ff;
      end else if (multi_sel) begin
         cur_chan = {chan_code[3:2], count_ff[1:0]};
         cur_slot = {1'b1, count_ff[1:0]};
      end else if (eight_sel) begin
         cur_slot = count_ff;
      end else begin
         cur_slot = {1'b1, count_ff[1:0]};
      end
      eff_chan = (cur_chan[3:2] == 2'b10) ? 4'hD : cur_chan;
   end
   // Timing: sample phase then SAR bits, padded to a fixed conversion slot
   always @* begin
      nxt_state = state_ff;
      nxt_count = count_ff;
      case (state_ff)
         ST_IDLE: begin
            nxt_state = ST_IDLE;
         end
         ST_SAMPLE: begin
            if (step && tick_ff == `ADCSQ_SAMPLE_CYCLES - 1) begin
               nxt_state = ST_CONV;
            end
         end
         ST_CONV: begin
            // Sample plus conversion slot fills the per-conversion budget
            if (step && tick_ff == `ADCSQ_CONV_CYCLES - `ADCSQ_SAMPLE_CYCLES - 1) begin
               if ((eight_sel ? count_ff == 3'd7 : count_ff[1:0] == 2'd3) && !scan) begin
                  nxt_state = ST_IDLE;
                  nxt_count = 3'd0;
               end else begin
                  nxt_state = ST_SAMPLE;
                  nxt_count = eight_sel ? count_ff + 3'd1 : {1'b0, count_ff[1:0] + 2'd1};
               end
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end
   assign sar_start = (state_ff == ST_SAMPLE) & step & (tick_ff == `ADCSQ_SAMPLE_CYCLES - 1);
   // Compare passes two sync flops, so bus-clock steps wait three cycles
   assign sar_step  = clk_sel_ff ? osc_rise :
                      ((state_ff == ST_CONV) & (tick_ff % 6'd3 == 6'd2));
   adcsq_sar #(
      .WIDTH     (RES_BITS)
   ) u_sar (
      .pclk      (pclk),
      .presetn   (presetn),
      .abort     (abort),
      .step      (sar_step),
      .start     (sar_start),
      .cmp_above (cmp_s2_ff),
      .dac_code  (dac_code),
      .done_ff   (sar_done)
   );
   // Sequencer, results and done flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff       <= ST_IDLE;
         count_ff       <= 3'd0;
         tick_ff        <= 6'd0;
         mux_sel_ff     <= 4'h0;
         sample_hold_ff <= 1'b0;
         conv_total_ff  <= 8'h00;
         ctrl_ff        <= `ADCSQ_CTRL_RESET;
         for (i = 0; i < 8; i = i + 1) begin
            result_ff[i] <= {RES_BITS{1'b0}};
         end
      end else begin
         if (ctrl_wr) begin
            ctrl_ff  <= {1'b0, pwdata[6:0]};
            state_ff <= converter_power_on_ff ? ST_SAMPLE : ST_IDLE;
            count_ff <= 3'd0;
            tick_ff  <= 6'd0;
            conv_total_ff <= 8'h00;
            sample_hold_ff <= 1'b0;
         end else if (!converter_power_on_ff) begin
            state_ff <= ST_IDLE;
            count_ff <= 3'd0;
            tick_ff  <= 6'd0;
            sample_hold_ff <= 1'b0;
         end else begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            if (nxt_state != state_ff) begin
               tick_ff <= 6'd0;
            end else if (step && state_ff != ST_IDLE) begin
               tick_ff <= tick_ff + 6'd1;
            end
            mux_sel_ff     <= eff_chan;
            sample_hold_ff <= (state_ff == ST_SAMPLE);
            // One channel moves per bus cycle at most
            if (sar_done) begin
               result_ff[cur_slot] <= dac_code;
               if ((eight_sel ? count_ff == 3'd7 : count_ff[1:0] == 2'd3)) begin
                  ctrl_ff[`ADCSQ_CTRL_DONE] <= 1'b1;
               end
               conv_total_ff <= conv_total_ff + 8'h01;
            end
         end
      end
   end
   // Option register: power and clock source
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_power_on_ff <= 1'b0;
         clk_sel_ff            <= 1'b0;
      end else if (wr_en && paddr == `ADCSQ_OFS_OPTION) begin
         converter_power_on_ff <= pwdata[`ADCSQ_OPT_PWR];
         clk_sel_ff            <= pwdata[`ADCSQ_OPT_CLKSEL];
      end
   end
   // Read data registered in setup phase, so ready can stay high
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_en) begin
         prdata <= 32'h00000000;
         if (paddr == `ADCSQ_OFS_CTRL) begin
            prdata <= {24'h000000, ctrl_ff};
         end else if (paddr == `ADCSQ_OFS_OPTION) begin
            prdata <= {30'h00000000, clk_sel_ff, converter_power_on_ff};
         end else if (paddr == `ADCSQ_OFS_STATUS) begin
            prdata <= {21'h000000, state_ff, conv_total_ff};
         end else if (paddr >= `ADCSQ_OFS_RESULT0 && paddr <= 12'h02C && paddr[1:0] == 2'b00) begin
            prdata <= {16'h0000, result_ff[paddr[4:2] - 3'd4], 6'h00};
         end
      end
   end
endmodule // adcsq_top

// ### tb/adcsq_assertions.sv
// Port checks for the converter sequencer
`timescale 1ns/1ps
module adcsq_assertions (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire [3:0]  mux_sel_ff,
   input wire        sample_hold_ff,
   input wire        converter_power_on_ff
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire       wr = psel && penable && pwrite;
   reg        osc_sel_ff;
   reg  [4:0] ctl_ff;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_sel_ff <= 1'b0;
         ctl_ff     <= 5'h00;
      end else if (wr && paddr == 12'h004) begin
         osc_sel_ff <= pwdata[1];
      end else if (wr && paddr == 12'h000) begin
         ctl_ff     <= pwdata[4:0];
      end
   end
   property p_no_reserved;
      mux_sel_ff[3:2] != 2'b10;
   endproperty
   a_no_reserved: assert property (p_no_reserved) else $error("reserved mux code");
   property p_format;
      psel && !penable && !pwrite && paddr >= 12'h010 && paddr <= 12'h02C
         |=> prdata[5:0] == 6'h00 && prdata[31:16] == 16'h0000;
   endproperty
   a_format: assert property (p_format) else $error("result format");
   property p_off_idle;
      !converter_power_on_ff [*2] |-> !sample_hold_ff;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("sampling while off");
   property p_power_wr;
      wr && paddr == 12'h004 |=> converter_power_on_ff == $past(pwdata[0]);
   endproperty
   a_power_wr: assert property (p_power_wr) else $error("power bit");
   // Control and power-off writes abort, so a window with any write in it is not judged
   property p_sample_len;
      disable iff (!presetn || wr)
      $rose(sample_hold_ff) && !osc_sel_ff |-> sample_hold_ff [*4] ##1 !sample_hold_ff;
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("sample length");
   property p_start;
      wr && paddr == 12'h000 && converter_power_on_ff && !osc_sel_ff |-> ##[1:6] sample_hold_ff;
   endproperty
   a_start: assert property (p_start) else $error("no restart");
   property p_decode;
      sample_hold_ff && $past(sample_hold_ff) && !ctl_ff[4]
         |-> mux_sel_ff == (ctl_ff[3:2] == 2'b10 ? 4'hD : ctl_ff[3:0]);
   endproperty
   a_decode: assert property (p_decode) else $error("mux decode");
   property p_mux_hold;
      sample_hold_ff && $past(sample_hold_ff) |-> $stable(mux_sel_ff);
   endproperty
   a_mux_hold: assert property (p_mux_hold) else $error("mux moved");
endmodule  // adcsq_assertions

// ### tb/adcsq_analog_model.sv
// Analog mux, sample capacitor and comparator model
`timescale 1ns/1ps
module adcsq_analog_model (
   input  wire       pclk,
   input  wire [3:0] mux_sel_ff,
   input  wire       sample_hold_ff,
   input  wire [9:0] dac_code,
   input  wire [9:0] pin_level,
   output wire       cmp_above
);
   reg [9:0] held_ff = 10'h000;
   reg [9:0] lvl;
   // All pins share one level; enough to tell pins from references
   always @* begin
      case (mux_sel_ff)
         4'hC:    lvl = 10'h3FF;
         4'hD:    lvl = 10'h000;
         4'hE:    lvl = 10'h200;
         4'hF:    lvl = 10'h155;
         default: lvl = pin_level;
      endcase
   end
   always @(posedge pclk) if (sample_hold_ff) held_ff <= lvl;
   assign cmp_above = held_ff >= dac_code;
endmodule  // adcsq_analog_model

// ### tb/tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb;
   reg         pclk      = 1'b0;
   reg         presetn   = 1'b0;
   reg         psel      = 1'b0;
   reg         penable   = 1'b0;
   reg         pwrite    = 1'b0;
   reg  [11:0] paddr     = 12'h000;
   reg  [31:0] pwdata    = 32'h0;
   reg         osc_clk   = 1'b0;
   reg  [9:0]  pin_level = 10'h2AB;
   reg  [31:0] rd;
   wire        pready, pslverr, cmp_above, sample_hold_ff, converter_power_on_ff;
   wire [31:0] prdata;
   wire [3:0]  mux_sel_ff;
   wire [9:0]  dac_code;
   integer     num_errors = 0;
   integer     total_checks = 0;
   integer     i, n;
   adcsq_top adcsq_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .osc_clk(osc_clk), .cmp_above(cmp_above), .mux_sel_ff(mux_sel_ff),
      .sample_hold_ff(sample_hold_ff), .dac_code(dac_code),
      .converter_power_on_ff(converter_power_on_ff));
   adcsq_analog_model adcsq_analog_model_i (.pclk(pclk), .mux_sel_ff(mux_sel_ff),
      .sample_hold_ff(sample_hold_ff), .dac_code(dac_code), .pin_level(pin_level),
      .cmp_above(cmp_above));
   initial forever #10 pclk = ~pclk;
   initial forever #333 osc_clk = ~osc_clk;
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel    <= 1'b1;
         pwrite  <= w;
         paddr   <= a;
         pwdata  <= d;
         @(posedge pclk) penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rd = prdata;
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   // Poll the done flag; n counts cycles since the start
   task run(input [31:0] ctl, input integer lim);
      begin
         apb(1, 12'h000, ctl);
         n = 0;
         rd = 0;
         while (rd[7] !== 1'b1 && n < lim) begin
            apb(0, 12'h000, 0);
            n = n + 3;
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", total_checks, num_errors);
         if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task t_basic;
      begin
         apb(0, 12'h000, 0);
         chk(rd, 0);
         apb(1, 12'h100, 32'hFFFFFFFF);
         apb(0, 12'h100, 0);
         chk(rd, 0);
         chk(pslverr, 0);
         apb(1, 12'h004, 1);
         repeat (5000) @(posedge pclk);
         run(32'h03, 400);
         chk(n >= 141 && n <= 162, 1);
         for (i = 0; i < 8; i = i + 1) begin
            apb(0, 12'(16 + 4 * i), 0);
            chk(rd, i < 4 ? 32'h0 : {16'h0, pin_level, 6'h00});
         end
         chk(sample_hold_ff, 0);
         $display("test basic scan done");
      end
   endtask
   task t_codes;
      begin
         for (i = 8; i < 16; i = i + 1) begin
            run(i, 400);
            apb(0, 12'h02C, 0);
            chk(rd, {i == 12 ? 10'h3FF : i == 14 ? 10'h200 : i == 15 ? 10'h155 : 10'h0,
               6'h00});
         end
         pin_level <= 10'h0F1;
         run(32'h41, 800);
         for (i = 0; i < 8; i = i + 1) begin
            apb(0, 12'(16 + 4 * i), 0);
            chk(rd, {16'h0, 10'h0F1, 6'h00});
         end
         $display("test codes done");
      end
   endtask
   task t_abort;
      begin
         run(32'h23, 400);
         n = 0;
         repeat (40) @(posedge pclk) n = n + sample_hold_ff;
         chk(n > 0, 1);
         apb(1, 12'h000, 32'h03);
         repeat (60) @(posedge pclk);
         apb(1, 12'h004, 0);
         n = 0;
         repeat (200) @(posedge pclk) n = n + sample_hold_ff;
         chk(n, 0);
         apb(0, 12'h000, 0);
         chk(rd[7], 0);
         $display("test abort done");
      end
   endtask
   task t_osc;
      begin
         apb(1, 12'h004, 3);
         run(32'h03, 20000);
         chk(rd[7], 1);
         chk(n > 600, 1);
         apb(0, 12'h02C, 0);
         chk(rd, {16'h0, 10'h0F1, 6'h00});
         $display("test oscillator done");
      end
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_basic;
      t_codes;
      t_abort;
      t_osc;
      give_verdict;
   end
   // Whole run is near 12k cycles; this leaves ample margin
   initial begin
      #800000;
      num_errors = num_errors + 1;
      give_verdict;
   end
endmodule  // tb
bind adcsq_top adcsq_assertions adcsq_assertions_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .mux_sel_ff(mux_sel_ff), .sample_hold_ff(sample_hold_ff),
   .converter_power_on_ff(converter_power_on_ff));
